// ---- verilog/frmx_pkg.sv ----
package frmx_pkg;
    // instruction word layout
    localparam int OP_W = 14;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int OPC_MSB = 13;
    localparam int OPC_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam logic [5:0] OPC_MOVE_FROM_FILE = 6'h08;
    localparam logic DEST_WORK = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [6:0] ADDR_ZERO = 7'h00;
    localparam int FILE_DEPTH = 128;

    // execute phases: operand read, then destination write
    typedef enum logic [2:0] {
        FRMX_IDLE = 3'b001,
        FRMX_READ = 3'b010,
        FRMX_WRITE = 3'b100
    } frmx_state_e;
endpackage

// ---- verilog/frmx_file_mem.sv ----
`timescale 1ns/1ns
`default_nettype none
module frmx_file_mem
    import frmx_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // read port, data one cycle later
    input wire logic [ADDR_W-1:0] rdAddr,
    output logic [DATA_W-1:0] rdData,
    // write port
    input wire logic wrEn,
    input wire logic [ADDR_W-1:0] wrAddr,
    input wire logic [DATA_W-1:0] wrData
);
    logic [DATA_W-1:0] mem [FILE_DEPTH];
    logic [DATA_W-1:0] rdData_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // known contents after reset: each word holds its own address
            for (int i = 0; i < FILE_DEPTH; i++) begin
                mem[i] <= DATA_W'(i);
            end
        end else if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= DATA_ZERO;
        end else begin
            rdData_q <= mem[rdAddr];
        end
    end

    assign rdData = rdData_q;
endmodule // frmx_file_mem
`default_nettype wire

// ---- verilog/frmx_exec.sv ----
// Functional notes
// - move_from_file_op reads addressed file register, delivers value per destination bit.
// - destination bit 0: value goes to working register, file register unchanged.
// - destination bit 1: value written back to same file register, working untouched.
// - zero flag set when moved value is zero, cleared otherwise.
`timescale 1ns/1ns
`default_nettype none
module frmx_exec
    import frmx_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // instruction issue
    input wire logic instValid,
    input wire logic [OP_W-1:0] instWord,
    // results
    output logic [DATA_W-1:0] workReg,
    output logic zeroFlag,
    output logic busy,
    output logic done,
    output logic flush
);
    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic isMove;
    logic [ADDR_W-1:0] instAddr;
    assign isMove = instWord[OPC_MSB:OPC_LSB] == OPC_MOVE_FROM_FILE;
    assign instAddr = instWord[ADDR_W-1:0];

    frmx_state_e state_q, state_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic dest_q, dest_d;
    logic [DATA_W-1:0] work_q, work_d;
    logic zero_q, zero_d;
    logic done_q, done_d;
    logic memWr;
    logic [DATA_W-1:0] memRd;

    // ----------------------------------------
    // file register storage
    // ----------------------------------------
    // read address follows addr_d so the operand is registered before the write phase
    frmx_file_mem u_mem (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .rdAddr(addr_d),
        .rdData(memRd),
        .wrEn(memWr),
        .wrAddr(addr_q),
        .wrData(memRd)
    );

    // ----------------------------------------
    // execute sequence
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        dest_d = dest_q;
        work_d = work_q;
        zero_d = zero_q;
        done_d = 1'b0;
        memWr = 1'b0;
        case (state_q)
            FRMX_IDLE: begin
                if (instValid && isMove) begin
                    addr_d = instAddr;
                    dest_d = instWord[DEST_BIT];
                    state_d = FRMX_READ;
                end
            end
            FRMX_READ: begin
                state_d = FRMX_WRITE;
            end
            FRMX_WRITE: begin
                if (dest_q == DEST_WORK) begin
                    work_d = memRd;
                end else begin
                    // write-back rewrites the word just read
                    memWr = 1'b1;
                end
                zero_d = memRd == DATA_ZERO;
                done_d = 1'b1;
                state_d = FRMX_IDLE;
            end
            default: begin
                state_d = FRMX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= FRMX_IDLE;
            addr_q <= ADDR_ZERO;
            dest_q <= DEST_WORK;
            work_q <= DATA_ZERO;
            zero_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            dest_q <= dest_d;
            work_q <= work_d;
            zero_q <= zero_d;
            done_q <= done_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    logic busy_q, busy_d;
    logic flush_q, flush_d;

    // busy follows the next state so it rises with the taking edge
    always_comb begin
        busy_d = state_d != FRMX_IDLE;
        flush_d = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            flush_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
            flush_q <= flush_d;
        end
    end

    assign workReg = work_q;
    assign zeroFlag = zero_q;
    assign busy = busy_q;
    assign done = done_q;
    assign flush = flush_q;

    // ----------------------------------------
    // checks: execute sequence, off while reset is low
    // ----------------------------------------
    chk_done_latency: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == FRMX_IDLE && instValid && isMove) |-> ##3 done)
        else $error("move did not finish in three cycles");
    chk_busy_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == FRMX_IDLE && instValid && isMove) |=> busy)
        else $error("busy did not rise on a taken move");
    chk_busy_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
        busy ##1 busy |=> !busy)
        else $error("busy stood longer than two cycles");
    chk_busy_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
        busy == (state_q != FRMX_IDLE))
        else $error("busy disagrees with execute state");
    chk_busy_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
        done |-> !busy)
        else $error("busy still high at done");
    chk_done_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        done |=> !done)
        else $error("done longer than one cycle");
    chk_done_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        done |-> $past(state_q) == FRMX_WRITE)
        else $error("done without a write phase");
    chk_read_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == FRMX_READ |=> state_q == FRMX_WRITE)
        else $error("read phase not followed by write phase");
    chk_write_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == FRMX_WRITE |=> state_q == FRMX_IDLE)
        else $error("write phase not followed by idle");
    chk_idle_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == FRMX_IDLE && !(instValid && isMove)) |=> (!busy && state_q == FRMX_IDLE))
        else $error("execute started without a move");
    chk_refuse_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q != FRMX_IDLE) |=> ($stable(addr_q) && $stable(dest_q)))
        else $error("operand changed during execute");
    chk_mem_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q != FRMX_IDLE) |-> addr_d == addr_q)
        else $error("read address moved during execute");
    chk_write_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
        memWr |=> !memWr)
        else $error("file written twice for one move");

    // ----------------------------------------
    // checks: operand and destination
    // ----------------------------------------
    chk_work_dest: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == FRMX_WRITE && dest_q == DEST_WORK) |=> workReg == $past(memRd))
        else $error("working register not loaded");
    chk_work_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == FRMX_WRITE && dest_q == DEST_FILE) |=> $stable(workReg))
        else $error("working register changed on file write-back");
    chk_file_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        memWr |-> (state_q == FRMX_WRITE && dest_q == DEST_FILE && memRd == $past(memRd)))
        else $error("file write outside write-back or with another value");
    chk_zero_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        done |-> zeroFlag == ($past(memRd) == DATA_ZERO))
        else $error("zero flag wrong");
    chk_zero_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !done |-> $stable(zeroFlag))
        else $error("zero flag changed without a move");
    chk_addr_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == FRMX_IDLE && instValid && isMove) |=> addr_q == $past(instAddr))
        else $error("operand address not captured");
    chk_no_flush: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !flush)
        else $error("flush raised");
    chk_dest_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == FRMX_IDLE && instValid && isMove) |=> dest_q == $past(instWord[DEST_BIT]))
        else $error("destination bit not captured");

    // working register holds between moves, zero flag matches the moved value
    chk_work_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !done |-> $stable(workReg))
        else $error("working register changed without a move");
    chk_zero_work: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == FRMX_WRITE && dest_q == DEST_WORK) |=> zeroFlag == (workReg == DATA_ZERO))
        else $error("zero flag disagrees with working register");
    chk_zero_file: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == FRMX_WRITE && dest_q == DEST_FILE && memRd == DATA_ZERO) |=> zeroFlag)
        else $error("zero test by write-back missed");
    chk_zero_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == FRMX_WRITE && memRd != DATA_ZERO) |=> !zeroFlag)
        else $error("zero flag set for a nonzero value");
endmodule // frmx_exec
`default_nettype wire

// ---- tb/tb_file_register_move_exec.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_file_register_move_exec import frmx_pkg::*; ;
    // --------
    // stimulus
    // --------
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic instValid = 1'b0;
    logic [OP_W-1:0] instWord = '0;
    logic [DATA_W-1:0] workReg;
    logic zeroFlag;
    logic busy;
    logic done;
    logic flush;
    int errors = 0;
    int check_count = 0;

    always #2 clk_sys = ~clk_sys;

    frmx_exec dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .instValid(instValid),
        .instWord(instWord), .workReg(workReg), .zeroFlag(zeroFlag), .busy(busy),
        .done(done), .flush(flush));

    // --------
    // helpers
    // --------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input logic b, input logic d);
        @(negedge clk_sys);
        check("busy", 8'(busy), 8'(b));
        check("done", 8'(done), 8'(d));
        check("flush", 8'(flush), 8'h00);
    endtask

    // one request, taken at the next rising edge
    task automatic issue(input logic [5:0] opc, input logic dst, input logic [6:0] adr);
        instValid = 1'b1;
        instWord = {opc, dst, adr};
        @(negedge clk_sys);
        instValid = 1'b0;
    endtask

    task automatic close_out();
        if (errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // --------
    // scenarios
    // --------
    // file words hold their own address after reset
    task automatic move_to_file();
        issue(OPC_MOVE_FROM_FILE, DEST_FILE, 7'h05);
        step(1'b1, 1'b0);
        step(1'b0, 1'b1);
        check("workReg", workReg, DATA_ZERO);
        check("zeroFlag", 8'(zeroFlag), 8'h00);
        repeat (2) step(1'b0, 1'b0);
    endtask

    // second request arrives while the first executes and is dropped
    task automatic refused_while_busy();
        instValid = 1'b1;
        instWord = {OPC_MOVE_FROM_FILE, DEST_WORK, 7'h10};
        @(negedge clk_sys);
        instWord = {OPC_MOVE_FROM_FILE, DEST_WORK, 7'h11};
        check("busy", 8'(busy), 8'h01);
        @(negedge clk_sys);
        instValid = 1'b0;
        step(1'b0, 1'b1);
        check("workReg", workReg, 8'h10);
        check("zeroFlag", 8'(zeroFlag), 8'h00);
        repeat (4) step(1'b0, 1'b0);
    endtask

    task automatic back_to_back();
        issue(OPC_MOVE_FROM_FILE, DEST_FILE, 7'h7F);
        step(1'b1, 1'b0);
        step(1'b0, 1'b1);
        check("zeroFlag", 8'(zeroFlag), 8'h00);
        // next request while done stands is taken at once
        issue(OPC_MOVE_FROM_FILE, DEST_FILE, 7'h00);
        check("busy", 8'(busy), 8'h01);
        step(1'b1, 1'b0);
        step(1'b0, 1'b1);
        check("workReg", workReg, 8'h10);
        check("zeroFlag", 8'(zeroFlag), 8'h01);
        // the rewritten word must still hold its value
        issue(OPC_MOVE_FROM_FILE, DEST_WORK, 7'h7F);
        step(1'b1, 1'b0);
        step(1'b0, 1'b1);
        check("workReg", workReg, 8'h7F);
        check("zeroFlag", 8'(zeroFlag), 8'h00);
    endtask

    task automatic other_opcodes();
        for (int k = 0; k < 6; k++) begin
            issue(OPC_MOVE_FROM_FILE ^ 6'(1 << k), DEST_WORK, 7'h03);
            repeat (3) step(1'b0, 1'b0);
        end
        check("workReg", workReg, 8'h7F);
    endtask

    task automatic reset_mid_move();
        issue(OPC_MOVE_FROM_FILE, DEST_WORK, 7'h22);
        rst_n = 1'b0;
        step(1'b0, 1'b0);
        check("workReg", workReg, DATA_ZERO);
        check("zeroFlag", 8'(zeroFlag), 8'h00);
        rst_n = 1'b1;
        move_to_file();
    endtask

    initial begin
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        check("workReg", workReg, DATA_ZERO);
        check("zeroFlag", 8'(zeroFlag), 8'h00);
        move_to_file();
        refused_while_busy();
        back_to_back();
        other_opcodes();
        reset_mid_move();
        close_out();
    end
endmodule // tb_file_register_move_exec
`default_nettype wire
